// file: design/ueoa_top.sv
// Top: pipe empty/overrun flags, stall forcing, device address and bus slave
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ueoa_top (
  input  wire logic                                   mclk,
  input  wire logic                                   sys_rst,
  input  wire logic                                   soft_rst,
  input  wire logic [ueoa_pkg::ADDR_W-1:0]            avs_address,
  input  wire logic                                   avs_read,
  input  wire logic                                   avs_write,
  input  wire logic [ueoa_pkg::DATA_W-1:0]            avs_writedata,
  output logic      [ueoa_pkg::DATA_W-1:0]            avs_readdata,
  output logic                                        avs_waitrequest,
  input  wire logic [ueoa_pkg::NUM_FLAGS-1:0]         pipe_is_in,
  input  wire logic [ueoa_pkg::NUM_FLAGS-1:0]         pipe_buf_drained,
  input  wire logic [ueoa_pkg::NUM_FLAGS-1:0]         pipe_pkt_done,
  input  wire logic [ueoa_pkg::PKT_LEN_W-1:0]         rx_pkt_len,
  input  wire logic [ueoa_pkg::NUM_GPIPES*ueoa_pkg::MPS_W-1:0] gpipe_max_pkt_size,
  input  wire logic                                   set_addr_req,
  input  wire logic [ueoa_pkg::USB_ADDR_W-1:0]        set_addr_value,
  input  wire logic                                   status_stage_done,
  output logic      [ueoa_pkg::NUM_FLAGS-1:0]         stall_force,
  output logic      [ueoa_pkg::USB_ADDR_W-1:0]        usb_device_address,
  output logic                                        irq
);
  import ueoa_pkg::*;

  // ----------------------------------------------------------------
  // Bus request decode
  // ----------------------------------------------------------------
  ueoa_bus_req_s           req;
  ueoa_bus_st_e            bus_st_ff;
  ueoa_pipe_ev_s           ev;
  logic [NUM_FLAGS-1:0]    flags_ff;
  logic [NUM_FLAGS-1:0]    mask_ff;
  logic [NUM_FLAGS-1:0]    set_ev;
  logic [NUM_FLAGS-1:0]    clr_ev;
  logic [NUM_FLAGS-1:0]    oversize;
  logic                    clk_en_ff;
  logic [MPS_W-1:0]        ctrl_mps_ff;
  logic [USB_ADDR_W-1:0]   addr_ff;
  logic [USB_ADDR_W-1:0]   pend_addr_ff;
  logic                    pend_valid_ff;
  logic                    wr_go;
  logic                    rd_go;
  logic [DATA_W-1:0]       nxt_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [MPS_W-1:0] pipe_mps(input int idx,
                                                input logic [MPS_W-1:0] cmps,
                                                input logic [NUM_GPIPES*MPS_W-1:0] g);
    if (idx == 0) begin
      pipe_mps = cmps;
    end else begin
      pipe_mps = g[(idx-1)*MPS_W +: MPS_W];
    end
  endfunction

  assign req = {avs_address, avs_read, avs_write, avs_writedata};
  assign ev  = {pipe_is_in, pipe_buf_drained, pipe_pkt_done};

  // One wait cycle: read data is caught on the first edge, a write lands
  // on the edge where waitrequest is seen low
  assign wr_go = req.write && (bus_st_ff == ST_RESP);
  assign rd_go = req.read && (bus_st_ff == ST_IDLE);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_st_ff <= ST_IDLE;
    end else begin
      case (bus_st_ff)
        ST_IDLE: begin
          if (req.read || req.write) begin
            bus_st_ff <= ST_RESP;
          end
        end
        ST_RESP: begin
          bus_st_ff <= ST_IDLE;
        end
        default: begin
          bus_st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_st_ff == ST_IDLE && (req.read || req.write));
    end
  end

  // ----------------------------------------------------------------
  // Event detection per pipe
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_pipe
      logic [MPS_W-1:0] mps;
      assign mps = pipe_mps(gi, ctrl_mps_ff, gpipe_max_pkt_size);
      assign oversize[gi] = ev.pkt_done[gi] && !ev.is_in[gi]
                            && (rx_pkt_len > {{(PKT_LEN_W-MPS_W){1'b0}}, mps});
      assign set_ev[gi] = (ev.is_in[gi] && ev.buf_drained[gi])
                          || oversize[gi];
    end
  endgenerate

  // Zero bits clear, one bits ignored, several at once allowed
  assign clr_ev = (wr_go && hit(req.address, OFS_STATUS) && clk_en_ff)
                  ? ~req.writedata[NUM_FLAGS-1:0]
                  : '0;

  // ----------------------------------------------------------------
  // Flags, mask, stall forcing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff <= STATUS_RST[NUM_FLAGS-1:0];
    end else if (soft_rst) begin
      flags_ff <= STATUS_RST[NUM_FLAGS-1:0];
    end else begin
      flags_ff <= (flags_ff & ~clr_ev) | set_ev;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_force <= '0;
    end else begin
      stall_force <= oversize;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_ff     <= '0;
      clk_en_ff   <= 1'b1;
      ctrl_mps_ff <= MPS_RST;
    end else if (wr_go && hit(req.address, OFS_IRQ_MASK)) begin
      mask_ff <= req.writedata[NUM_FLAGS-1:0];
    end else if (wr_go && hit(req.address, OFS_CTRL)) begin
      clk_en_ff   <= req.writedata[CTRL_CLKEN];
      ctrl_mps_ff <= req.writedata[CTRL_MPS_LSB +: MPS_W];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((flags_ff & ~clr_ev) | set_ev) & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Device address capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_addr_ff  <= '0;
      pend_valid_ff <= 1'b0;
      addr_ff       <= USB_ADDR_RST[USB_ADDR_W-1:0];
    end else if (soft_rst) begin
      pend_addr_ff  <= '0;
      pend_valid_ff <= 1'b0;
      addr_ff       <= USB_ADDR_RST[USB_ADDR_W-1:0];
    end else if (set_addr_req) begin
      pend_addr_ff  <= set_addr_value;
      pend_valid_ff <= 1'b1;
    end else if (status_stage_done && pend_valid_ff) begin
      addr_ff       <= pend_addr_ff;
      pend_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      usb_device_address <= '0;
    end else begin
      usb_device_address <= addr_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    if (hit(req.address, OFS_STATUS)) begin
      nxt_rdata[NUM_FLAGS-1:0] = flags_ff;
    end else if (hit(req.address, OFS_USB_ADDR)) begin
      nxt_rdata[USB_ADDR_W-1:0] = addr_ff;
    end else if (hit(req.address, OFS_IRQ_MASK)) begin
      nxt_rdata[NUM_FLAGS-1:0] = mask_ff;
    end else if (hit(req.address, OFS_CTRL)) begin
      nxt_rdata[CTRL_CLKEN]              = clk_en_ff;
      nxt_rdata[CTRL_MPS_LSB +: MPS_W]   = ctrl_mps_ff;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (rd_go) begin
      avs_readdata <= nxt_rdata;
    end
  end
endmodule
`default_nettype wire

// file: design/ueoa_pkg.sv
// Package: register map, field layout and timing constants for the pipe status block
`default_nettype none
//
// Summary of operation
// - IN pipe drained sets its flag
// - OUT pipe oversized packet sets flag
// - Pipe oversize forces handshake field to stall
// - Control pipe IN drained sets flag
// - Control pipe OUT over max size sets flag
// - Control pipe oversize forces stall response
// - Writing zero clears a flag
// - No clearing while internal clock stopped
// - Writing one leaves flag unchanged
// - One write may clear several flags
// - Seven-bit address field, read only
// - Address captured after SET_ADDRESS status stage
// - Upper nine address bits read zero
// - Address register resets to zero
package ueoa_pkg;
  localparam int          NUM_FLAGS     = 7;
  localparam int          NUM_GPIPES    = 6;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          USB_ADDR_W    = 7;
  localparam int          MPS_W         = 7;
  localparam int          PKT_LEN_W     = 11;
  localparam int          HS_W          = 2;
  localparam logic [7:0]  OFS_STATUS    = 8'h6c;
  localparam logic [7:0]  OFS_USB_ADDR  = 8'h74;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h90;
  localparam logic [7:0]  OFS_CTRL      = 8'h94;
  localparam int          CTRL_CLKEN    = 0;
  localparam int          CTRL_MPS_LSB  = 8;
  localparam logic [15:0] STATUS_RST    = 16'h0000;
  localparam logic [15:0] USB_ADDR_RST  = 16'h0000;
  localparam logic [1:0]  HS_STALL      = 2'h2;
  localparam logic [6:0]  MPS_RST       = 7'h40;
  localparam int          CLEAR_GAP_NS  = 100;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          CLEAR_GAP_CYC = (CLEAR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [NUM_FLAGS-1:0] is_in;
    logic [NUM_FLAGS-1:0] buf_drained;
    logic [NUM_FLAGS-1:0] pkt_done;
  } ueoa_pipe_ev_s;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
  } ueoa_bus_req_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESP = 2'b01
  } ueoa_bus_st_e;
endpackage
`default_nettype wire

// file: verif/ueoa_sva.sv
// Checker: bus timing, stall forcing and address register
`timescale 1ns/1ps
`default_nettype none
module ueoa_sva (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        soft_rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [6:0]  pipe_is_in,
  input wire logic [6:0]  pipe_pkt_done,
  input wire logic [10:0] rx_pkt_len,
  input wire logic [41:0] gpipe_max_pkt_size,
  input wire logic        status_stage_done,
  input wire logic [6:0]  stall_force,
  input wire logic [6:0]  usb_device_address
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low");
  a_stall_pipe_one: assert property (
    pipe_pkt_done[1] && !pipe_is_in[1] && rx_pkt_len > {4'h0, gpipe_max_pkt_size[6:0]}
    |=> stall_force[1]) else $error("stall one");
  a_stall_pipe_six: assert property (
    pipe_pkt_done[6] && !pipe_is_in[6] && rx_pkt_len > {4'h0, gpipe_max_pkt_size[41:35]}
    |=> stall_force[6]) else $error("stall six");
  a_ctrl_stall_cause: assert property (
    stall_force[0] |-> $past(pipe_pkt_done[0] && !pipe_is_in[0])) else $error("stall cause");
  a_addr_hold: assert property (
    $changed(usb_device_address) |-> $past(status_stage_done || soft_rst, 2)
    || $past(status_stage_done || soft_rst)) else $error("addr moved");
  a_addr_upper: assert property (
    !avs_waitrequest && $past(avs_read && avs_address == ueoa_pkg::OFS_USB_ADDR)
    |-> avs_readdata[31:7] == 25'h0) else $error("upper bits");
  a_addr_soft: assert property (soft_rst |=> ##1 usb_device_address == 7'h0)
    else $error("addr soft");
endmodule
bind ueoa_top ueoa_sva u_sva (.*);
`default_nettype wire

// file: verif/ueoa_host_model.sv
// Partner: host side pipe traffic and address setting transfers
`timescale 1ns/1ps
`default_nettype none
module ueoa_host_model (
  input  wire logic        mclk,
  output logic      [6:0]  pipe_is_in,
  output logic      [6:0]  pipe_buf_drained,
  output logic      [6:0]  pipe_pkt_done,
  output logic      [10:0] rx_pkt_len,
  output logic             set_addr_req,
  output logic      [6:0]  set_addr_value,
  output logic             status_stage_done
);
  initial begin
    {pipe_is_in, pipe_buf_drained, pipe_pkt_done, rx_pkt_len} = '0;
    {set_addr_req, set_addr_value, status_stage_done} = '0;
  end
  // Drained pulse on IN, packet end with length on OUT
  task automatic ev(input int p, input logic in, input logic [10:0] l);
    @(posedge mclk);
    pipe_is_in[p] <= in;
    pipe_buf_drained[p] <= in;
    pipe_pkt_done[p] <= !in;
    rx_pkt_len <= l;
    @(posedge mclk);
    pipe_buf_drained <= '0;
    pipe_pkt_done <= '0;
    rx_pkt_len <= ~l;
  endtask
  // Setup stage carries the address, status stage ends later
  task automatic addr(input logic [6:0] a);
    @(posedge mclk);
    set_addr_req <= 1'b1;
    set_addr_value <= a;
    @(posedge mclk);
    set_addr_req <= 1'b0;
    set_addr_value <= ~a;
    repeat (4) @(posedge mclk);
    status_stage_done <= 1'b1;
    @(posedge mclk);
    status_stage_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verif/usb_pipe_empty_overrun_and_address_test.sv
// Testbench: flags, clock gate, address capture and register bus
`timescale 1ns/1ps
`default_nettype none
module usb_pipe_empty_overrun_and_address_test;
  import ueoa_pkg::*;
  logic        mclk = 0;
  logic        sys_rst = 1;
  logic        soft_rst = 0;
  logic [7:0]  avs_address = '0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, irq, set_addr_req, status_stage_done, in;
  logic [6:0]  pipe_is_in, pipe_buf_drained, pipe_pkt_done, set_addr_value, mx;
  logic [6:0]  stall_force, usb_device_address, exp_st;
  logic [10:0] rx_pkt_len, l;
  logic [41:0] gpipe_max_pkt_size = '0;
  logic [15:0] r = 16'h90e0;
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  always #5 mclk = ~mclk;
  ueoa_top dut (.*);
  ueoa_host_model host (.*);
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic flag_exp(input logic i, input logic [10:0] ln, input logic [6:0] m);
    return i || ln > {4'h0, m};
  endfunction
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic st_chk(input string s);
    bus(0, OFS_STATUS, 0);
    chk(s, q, {25'h0, exp_st});
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    end_sim;
  end
  initial begin
    for (int p = 0; p < 6; p++) begin
      r = nx(r);
      gpipe_max_pkt_size[p*7 +: 7] = r[6:0] | 7'h1;
    end
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(0, OFS_USB_ADDR, 0);
    chk("addr_reset", q, 0);
    bus(0, 8'h20, 0);
    chk("unmapped", q, 0);
    bus(1, OFS_IRQ_MASK, 32'h7f);
    exp_st = '0;
    for (int p = 0; p < 7; p++) begin
      r = nx(r);
      in = p == 6 || (p != 0 && r[2]);
      mx = p ? gpipe_max_pkt_size[p*7-7 +: 7] : MPS_RST;
      l = {4'h0, mx} + r[1:0] - 11'h1;
      host.ev(p, in, l);
      exp_st[p] = flag_exp(in, l, mx);
    end
    st_chk("flags");
    chk("irq_on", irq, |exp_st);
    bus(1, OFS_STATUS, 32'h7f);
    st_chk("write_one");
    bus(1, OFS_CTRL, {17'h0, MPS_RST, 8'h0});
    bus(1, OFS_STATUS, 0);
    st_chk("gated");
    bus(1, OFS_CTRL, {17'h0, MPS_RST, 8'h1});
    bus(1, OFS_STATUS, 32'h3f);
    exp_st[6] = 1'b0;
    st_chk("clear_one");
    repeat (CLEAR_GAP_CYC) @(posedge mclk);
    bus(1, OFS_STATUS, 0);
    exp_st = '0;
    st_chk("clear_all");
    chk("irq_off", irq, 0);
    bus(1, OFS_IRQ_MASK, 0);
    host.ev(6, 1'b1, 11'h0);
    repeat (2) @(posedge mclk);
    chk("irq_masked", irq, 0);
    bus(1, OFS_IRQ_MASK, 32'h40);
    repeat (2) @(posedge mclk);
    chk("irq_unmasked", irq, 1);
    bus(1, OFS_STATUS, 0);
    bus(1, OFS_CTRL, {17'h0, 7'h08, 8'h1});
    host.ev(0, 1'b0, 11'h8);
    host.ev(0, 1'b0, 11'h9);
    host.ev(6, 1'b0, {4'h0, gpipe_max_pkt_size[41:35]} + 11'h1);
    exp_st = 7'h41;
    st_chk("oversize");
    repeat (CLEAR_GAP_CYC) @(posedge mclk);
    fork
      bus(1, OFS_STATUS, 0);
      begin
        @(posedge mclk);
        host.ev(0, 1'b1, 11'h0);
      end
    join
    exp_st = 7'h01;
    st_chk("set_wins");
    $display("test flags done");
    bus(1, OFS_USB_ADDR, 32'h7f);
    bus(0, OFS_USB_ADDR, 0);
    chk("addr_ro", q, 0);
    r = nx(r);
    host.addr(r[6:0] | 7'h1);
    bus(0, OFS_USB_ADDR, 0);
    chk("addr_new", q, {25'h0, r[6:0] | 7'h1});
    chk("addr_pin", usb_device_address, r[6:0] | 7'h1);
    soft_rst <= 1'b1;
    @(posedge mclk);
    soft_rst <= 1'b0;
    bus(0, OFS_USB_ADDR, 0);
    chk("addr_soft", q, 0);
    exp_st = '0;
    st_chk("status_soft");
    $display("test address done");
    end_sim;
  end
endmodule
`default_nettype wire
